/* include/fcw_pkg.sv */
// package: constants and types of the first flash configuration word block
package fcw_pkg;

  // ---------------------------------------------------------------
  // word layout
  // ---------------------------------------------------------------
  localparam int CW_W = 24;
  localparam int ADDR_W = 12;
  localparam int BIT_RSV15 = 15;
  localparam int BIT_SCAN_EN = 14;
  localparam int BIT_CODE_PROT_N = 13;
  localparam int BIT_WR_PROT_N = 12;
  localparam int BIT_DEBUG_N = 11;
  localparam int BIT_RSV10 = 10;
  localparam int EMU_SEL_LO = 8;
  localparam int EMU_SEL_W = 2;
  localparam int BIT_WDT_EN = 7;
  localparam int BIT_WIN_DIS = 6;
  localparam int BIT_PRESCALE = 4;
  localparam int POSTSCALE_LO = 0;
  localparam int POSTSCALE_W = 4;
  localparam int POSTRATIO_W = 16;
  localparam int PRERATIO_W = 8;

  localparam logic [CW_W-1:0] UNIMPL_ONES = 24'hFF0020;
  localparam logic [CW_W-1:0] ERASED_WORD = 24'hFFFFFF;

  localparam logic [EMU_SEL_W-1:0] EMU_PAIR_ONE = 2'h3;
  localparam logic [EMU_SEL_W-1:0] EMU_PAIR_TWO = 2'h2;
  localparam logic [EMU_SEL_W-1:0] EMU_PAIR_THREE = 2'h1;
  localparam logic [EMU_SEL_W-1:0] EMU_RESERVED = 2'h0;

  localparam logic [PRERATIO_W-1:0] PRESCALE_LONG = 8'h80;
  localparam logic [PRERATIO_W-1:0] PRESCALE_SHORT = 8'h20;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_WORD = 12'h000;
  localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] REG_CTRL = 12'h008;
  localparam logic [ADDR_W-1:0] REG_DECODE = 12'h00C;

  localparam int ST_VALID = 0;
  localparam int ST_LOADING = 1;
  localparam int ST_EMU_RSV = 2;
  localparam int ST_WIN_NO_EN = 3;
  localparam int ST_RSV10_BAD = 4;
  localparam int ST_PROG_BLOCKED = 5;
  localparam int ST_SCAN_KEPT = 6;
  localparam int CTRL_RELOAD = 0;

  localparam int DEC_SCAN = 0;
  localparam int DEC_CODE_PROT = 1;
  localparam int DEC_WR_ALLOW = 2;
  localparam int DEC_DEBUG = 3;
  localparam int DEC_EMU_LO = 4;
  localparam int DEC_WDT_EN = 7;
  localparam int DEC_WINDOWED = 8;
  localparam int DEC_PRE_LO = 16;

  // ---------------------------------------------------------------
  // types and helpers
  // ---------------------------------------------------------------
  typedef enum logic {FCW_LD_IDLE, FCW_LD_FETCH} fcw_ld_state_t;

  function automatic logic [CW_W-1:0] fcw_readback(
      input logic [CW_W-1:0] w);
    fcw_readback = w | UNIMPL_ONES;
  endfunction

  function automatic logic [POSTRATIO_W-1:0] fcw_pow2(
      input logic [POSTSCALE_W-1:0] e);
    fcw_pow2 = 16'h0001 << e;
  endfunction

endpackage

/* logic/fcw_loader.sv */
// module: fetches the configuration word from flash after each reset
`timescale 1ns/100ps
`default_nettype none
module fcw_loader
  import fcw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic rd_ack,
  input wire logic [CW_W-1:0] rd_data,
  output logic rd_req,
  output logic busy,
  output logic done,
  output logic [CW_W-1:0] word
);

  typedef struct packed {
    fcw_ld_state_t state;
    logic done;
    logic [CW_W-1:0] word;
  } fcw_ld_t;

  fcw_ld_t cur_reg;
  fcw_ld_t cur_next;

  // ---------------------------------------------------------------
  // fetch sequence
  // ---------------------------------------------------------------
  always_comb begin
    cur_next = cur_reg;
    cur_next.done = 1'b0;
    unique case (cur_reg.state)
      FCW_LD_IDLE: begin
        if (start) begin
          cur_next.state = FCW_LD_FETCH;
        end
      end
      FCW_LD_FETCH: begin
        if (rd_ack) begin
          cur_next.word = rd_data;
          cur_next.done = 1'b1;
          cur_next.state = FCW_LD_IDLE;
        end
      end
    endcase
  end

  // a reset of any kind starts a fetch at once
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_reg.state <= FCW_LD_FETCH; // [RULE_13]
      cur_reg.done <= 1'b0;
      cur_reg.word <= ERASED_WORD;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign rd_req = (cur_reg.state == FCW_LD_FETCH);
  assign busy = (cur_reg.state == FCW_LD_FETCH);
  assign done = cur_reg.done;
  assign word = cur_reg.word;

endmodule
`default_nettype wire

/* logic/fcw_decode.sv */
// module: combinational decode of the configuration word fields
`timescale 1ns/100ps
`default_nettype none
module fcw_decode
  import fcw_pkg::*;
(
  input wire logic [CW_W-1:0] word,
  output logic scan_en,
  output logic code_protect,
  output logic wr_allow,
  output logic debug_at_reset,
  output logic [2:0] emu_pair,
  output logic wdt_en,
  output logic wdt_windowed,
  output logic [PRERATIO_W-1:0] prescale,
  output logic [POSTRATIO_W-1:0] postscale,
  output logic emu_reserved,
  output logic win_no_en,
  output logic rsv10_bad
);

  logic [EMU_SEL_W-1:0] emu_sel;

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  always_comb begin
    emu_sel = word[EMU_SEL_LO +: EMU_SEL_W];
    scan_en = word[BIT_SCAN_EN]; // [RULE_03]
    code_protect = ~word[BIT_CODE_PROT_N]; // [RULE_04] [RULE_14]
    wr_allow = word[BIT_WR_PROT_N]; // [RULE_05]
    debug_at_reset = ~word[BIT_DEBUG_N]; // [RULE_06]
    // one-hot pair select; the reserved code routes nowhere
    emu_pair = 3'h0;
    unique case (emu_sel) // [RULE_08]
      EMU_PAIR_ONE: emu_pair = 3'h1;
      EMU_PAIR_TWO: emu_pair = 3'h2;
      EMU_PAIR_THREE: emu_pair = 3'h4;
      EMU_RESERVED: emu_pair = 3'h0;
    endcase
    emu_reserved = (emu_sel == EMU_RESERVED); // [RULE_08]
    wdt_en = word[BIT_WDT_EN]; // [RULE_09]
    // windowed mode only takes effect with the watchdog enabled
    wdt_windowed = ~word[BIT_WIN_DIS] & word[BIT_WDT_EN]; // [RULE_10]
    win_no_en = ~word[BIT_WIN_DIS] & ~word[BIT_WDT_EN]; // [RULE_10]
    prescale = word[BIT_PRESCALE] ? PRESCALE_LONG
                                  : PRESCALE_SHORT; // [RULE_11]
    postscale = fcw_pow2(word[POSTSCALE_LO +: POSTSCALE_W]); // [RULE_15]
    rsv10_bad = ~word[BIT_RSV10]; // [RULE_07]
  end

endmodule
`default_nettype wire

/* logic/fcw_top.sv */
// module: first flash configuration word latch, decode and APB access
//
// Overview of operation
// RULE_01: the upper byte and bit five always read back as one.
// RULE_02: the programmer writes zero to bit fifteen, which reads undefined.
// RULE_03: bit fourteen set enables the boundary-scan port, clear disables it.
// RULE_04: bit thirteen clear code-protects all program memory.
// RULE_05: bit twelve clear blocks every program memory write.
// RULE_06: bit eleven clear makes the device leave reset in debug mode.
// RULE_07: the programmer keeps reserved bit ten at one.
// RULE_08: the pair field selects pair one, two or three; code 00 is unused.
// RULE_09: bit seven set enables the watchdog, clear disables it.
// RULE_10: bit six clear selects windowed watchdog, needing the enable set.
// RULE_11: bit four set divides the prescaler by 128, clear by 32.
// RULE_12: programming over boundary scan cannot change the scan enable bit.
// RULE_13: every kind of reset reloads the latches from flash.
// RULE_14: programmed bits read zero, erased bits one, selecting defaults.
// RULE_15: the postscaler divides by two to the power of its field.
// RULE_16: decoded outputs change only when a configuration load completes.
`timescale 1ns/100ps
`default_nettype none
module fcw_top
  import fcw_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic SYS_RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic FLASH_RD_REQ,
  input wire logic FLASH_RD_ACK,
  input wire logic [CW_W-1:0] FLASH_RD_DATA,
  input wire logic PROG_WR_VALID,
  input wire logic [CW_W-1:0] PROG_WR_DATA,
  input wire logic PROG_VIA_SCAN,
  output logic FLASH_WR_EN,
  output logic [CW_W-1:0] FLASH_WR_DATA,
  output logic CFG_VALID,
  output logic SCAN_PORT_EN,
  output logic CODE_PROTECT,
  output logic PROG_MEM_WR_ALLOW,
  output logic DEBUG_AT_RESET,
  output logic PROG_PIN_PAIR_ONE,
  output logic PROG_PIN_PAIR_TWO,
  output logic PROG_PIN_PAIR_THREE,
  output logic WDT_ENABLE,
  output logic WDT_WINDOWED,
  output logic [PRERATIO_W-1:0] WDT_PRESCALE,
  output logic [POSTRATIO_W-1:0] WDT_POSTSCALE
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  // one record so every flop shares one reset and one update
  typedef struct packed {
    logic [CW_W-1:0] word;
    logic valid;
    logic scan_en;
    logic code_protect;
    logic wr_allow;
    logic debug_at_reset;
    logic [2:0] emu_pair;
    logic wdt_en;
    logic wdt_windowed;
    logic [PRERATIO_W-1:0] prescale;
    logic [POSTRATIO_W-1:0] postscale;
    logic emu_reserved;
    logic win_no_en;
    logic rsv10_bad;
    logic prog_blocked;
    logic scan_kept;
    logic reload_req;
    logic flash_wr_en;
    logic [CW_W-1:0] flash_wr_data;
    logic [31:0] prdata;
  } fcw_top_t;

  fcw_top_t cur_reg;
  fcw_top_t cur_next;

  // ---------------------------------------------------------------
  // internal nets
  // ---------------------------------------------------------------
  logic ld_start;
  logic ld_busy;
  logic ld_done;
  logic [CW_W-1:0] ld_word;
  logic dec_scan_en;
  logic dec_code_protect;
  logic dec_wr_allow;
  logic dec_debug;
  logic [2:0] dec_emu_pair;
  logic dec_wdt_en;
  logic dec_windowed;
  logic [PRERATIO_W-1:0] dec_prescale;
  logic [POSTRATIO_W-1:0] dec_postscale;
  logic dec_emu_rsv;
  logic dec_win_no_en;
  logic dec_rsv10_bad;
  logic setup_phase;
  logic access_phase;
  logic addr_hit;
  logic wr_access;
  logic [31:0] status_word;
  logic [31:0] decode_word;
  logic [31:0] read_value;

  // ---------------------------------------------------------------
  // loader and decoder
  // ---------------------------------------------------------------
  // other reset sources and a software reload start a fresh fetch
  assign ld_start = SYS_RESET | cur_reg.reload_req; // [RULE_13]

  fcw_loader u_loader (
    .clk(REF_CLK),
    .rst(RST),
    .start(ld_start),
    .rd_ack(FLASH_RD_ACK),
    .rd_data(FLASH_RD_DATA),
    .rd_req(FLASH_RD_REQ),
    .busy(ld_busy),
    .done(ld_done),
    .word(ld_word)
  );

  // pure logic; its result is latched only when a load completes
  fcw_decode u_decode (
    .word(ld_word),
    .scan_en(dec_scan_en),
    .code_protect(dec_code_protect),
    .wr_allow(dec_wr_allow),
    .debug_at_reset(dec_debug),
    .emu_pair(dec_emu_pair),
    .wdt_en(dec_wdt_en),
    .wdt_windowed(dec_windowed),
    .prescale(dec_prescale),
    .postscale(dec_postscale),
    .emu_reserved(dec_emu_rsv),
    .win_no_en(dec_win_no_en),
    .rsv10_bad(dec_rsv10_bad)
  );

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // writes act only in the access cycle, reads sample the setup cycle
  assign setup_phase = PSEL & ~PENABLE;
  assign access_phase = PSEL & PENABLE;
  assign wr_access = access_phase & PWRITE;

  always_comb begin
    unique case (PADDR)
      REG_WORD, REG_STATUS, REG_CTRL, REG_DECODE: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // status and decode views
  // ---------------------------------------------------------------
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_VALID] = cur_reg.valid;
    status_word[ST_LOADING] = ld_busy;
    status_word[ST_EMU_RSV] = cur_reg.emu_reserved;
    status_word[ST_WIN_NO_EN] = cur_reg.win_no_en;
    status_word[ST_RSV10_BAD] = cur_reg.rsv10_bad;
    status_word[ST_PROG_BLOCKED] = cur_reg.prog_blocked;
    status_word[ST_SCAN_KEPT] = cur_reg.scan_kept;
  end

  always_comb begin
    decode_word = 32'h0000_0000;
    decode_word[DEC_SCAN] = cur_reg.scan_en;
    decode_word[DEC_CODE_PROT] = cur_reg.code_protect;
    decode_word[DEC_WR_ALLOW] = cur_reg.wr_allow;
    decode_word[DEC_DEBUG] = cur_reg.debug_at_reset;
    decode_word[DEC_EMU_LO +: 3] = cur_reg.emu_pair;
    decode_word[DEC_WDT_EN] = cur_reg.wdt_en;
    decode_word[DEC_WINDOWED] = cur_reg.wdt_windowed;
    decode_word[DEC_PRE_LO +: PRERATIO_W] = cur_reg.prescale;
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    read_value = 32'h0000_0000;
    unique case (PADDR)
      // bit fifteen is returned as stored, whatever was programmed
      REG_WORD: begin
        read_value[CW_W-1:0] = fcw_readback(cur_reg.word); // [RULE_01]
      end
      REG_STATUS: begin
        read_value = status_word;
      end
      REG_CTRL: begin
        read_value = 32'h0000_0000;
      end
      REG_DECODE: begin
        read_value = decode_word;
      end
      default: begin
        read_value = 32'h0000_0000;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    cur_next = cur_reg;
    cur_next.flash_wr_en = 1'b0;
    cur_next.reload_req = 1'b0;

    // read data is captured in the setup cycle so the access is
    // zero-wait yet still driven from a flip-flop
    if (setup_phase && !PWRITE) begin
      cur_next.prdata = read_value;
    end

    // latches and decoded outputs move together, only on completion
    if (ld_done) begin // [RULE_16]
      cur_next.word = ld_word; // [RULE_13]
      cur_next.valid = 1'b1;
      cur_next.scan_en = dec_scan_en; // [RULE_03]
      cur_next.code_protect = dec_code_protect; // [RULE_04]
      cur_next.wr_allow = dec_wr_allow; // [RULE_05]
      cur_next.debug_at_reset = dec_debug; // [RULE_06]
      cur_next.emu_pair = dec_emu_pair; // [RULE_08]
      cur_next.wdt_en = dec_wdt_en; // [RULE_09]
      cur_next.wdt_windowed = dec_windowed; // [RULE_10]
      cur_next.prescale = dec_prescale; // [RULE_11]
      cur_next.postscale = dec_postscale; // [RULE_15]
      cur_next.emu_reserved = dec_emu_rsv;
      cur_next.win_no_en = dec_win_no_en;
      cur_next.rsv10_bad = dec_rsv10_bad;
    end

    // software write-one clear of the sticky flags
    if (wr_access && PADDR == REG_STATUS) begin
      if (PWDATA[ST_PROG_BLOCKED]) begin
        cur_next.prog_blocked = 1'b0;
      end
      if (PWDATA[ST_SCAN_KEPT]) begin
        cur_next.scan_kept = 1'b0;
      end
    end
    // a reload asked for during a fetch is dropped by the loader
    if (wr_access && PADDR == REG_CTRL && PWDATA[CTRL_RELOAD]) begin
      cur_next.reload_req = 1'b1; // [RULE_13]
    end

    // programmer writes; the sets come after the clears so they win
    if (PROG_WR_VALID) begin
      if (!cur_reg.wr_allow) begin
        cur_next.prog_blocked = 1'b1; // [RULE_05]
      end else begin
        cur_next.flash_wr_en = 1'b1;
        // unimplemented positions are always stored as one
        cur_next.flash_wr_data = PROG_WR_DATA | UNIMPL_ONES; // [RULE_01]
        if (PROG_VIA_SCAN) begin
          // scan-side programming keeps the stored scan enable
          cur_next.flash_wr_data[BIT_SCAN_EN] =
            cur_reg.word[BIT_SCAN_EN]; // [RULE_12]
          if (PROG_WR_DATA[BIT_SCAN_EN] != cur_reg.word[BIT_SCAN_EN]) begin
            cur_next.scan_kept = 1'b1; // [RULE_12]
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // reset values are the erased-word defaults until flash answers
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cur_reg.word <= ERASED_WORD; // [RULE_14]
      cur_reg.valid <= 1'b0;
      // decoded copies of the erased word
      cur_reg.scan_en <= 1'b1;
      cur_reg.code_protect <= 1'b0;
      cur_reg.wr_allow <= 1'b1;
      cur_reg.debug_at_reset <= 1'b0;
      cur_reg.emu_pair <= 3'h1;
      cur_reg.wdt_en <= 1'b1;
      cur_reg.wdt_windowed <= 1'b0;
      cur_reg.prescale <= PRESCALE_LONG;
      cur_reg.postscale <= 16'h8000;
      // flags and bus side start clear, flash write data all ones
      cur_reg.emu_reserved <= 1'b0;
      cur_reg.win_no_en <= 1'b0;
      cur_reg.rsv10_bad <= 1'b0;
      cur_reg.prog_blocked <= 1'b0;
      cur_reg.scan_kept <= 1'b0;
      cur_reg.reload_req <= 1'b0;
      cur_reg.flash_wr_en <= 1'b0;
      cur_reg.flash_wr_data <= ERASED_WORD;
      cur_reg.prdata <= 32'h0000_0000;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // read data leaves from a flip-flop
  assign PRDATA = cur_reg.prdata;
  // no wait states: every access ends in its first cycle
  assign PREADY = access_phase;
  // unmapped offsets answer with an error and change nothing
  assign PSLVERR = access_phase & ~addr_hit;
  assign FLASH_WR_EN = cur_reg.flash_wr_en;
  assign FLASH_WR_DATA = cur_reg.flash_wr_data;

  // configuration outputs hold between loads
  assign CFG_VALID = cur_reg.valid;
  assign SCAN_PORT_EN = cur_reg.scan_en;
  assign CODE_PROTECT = cur_reg.code_protect;
  assign PROG_MEM_WR_ALLOW = cur_reg.wr_allow;
  assign DEBUG_AT_RESET = cur_reg.debug_at_reset;
  // one-hot pairs; the reserved code drives none
  assign PROG_PIN_PAIR_ONE = cur_reg.emu_pair[0];
  assign PROG_PIN_PAIR_TWO = cur_reg.emu_pair[1];
  assign PROG_PIN_PAIR_THREE = cur_reg.emu_pair[2];
  assign WDT_ENABLE = cur_reg.wdt_en;
  assign WDT_WINDOWED = cur_reg.wdt_windowed;
  assign WDT_PRESCALE = cur_reg.prescale;
  assign WDT_POSTSCALE = cur_reg.postscale;

endmodule
`default_nettype wire

/* bench/fcw_top_props.sv */
// checker: port relations of the configuration word block
`timescale 1ns/100ps
`default_nettype none
module fcw_top_props
  import fcw_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic SYS_RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic FLASH_RD_REQ,
  input wire logic FLASH_RD_ACK,
  input wire logic PROG_WR_VALID,
  input wire logic PROG_VIA_SCAN,
  input wire logic FLASH_WR_EN,
  input wire logic [CW_W-1:0] FLASH_WR_DATA,
  input wire logic CFG_VALID,
  input wire logic SCAN_PORT_EN,
  input wire logic CODE_PROTECT,
  input wire logic PROG_MEM_WR_ALLOW,
  input wire logic DEBUG_AT_RESET,
  input wire logic PROG_PIN_PAIR_ONE,
  input wire logic PROG_PIN_PAIR_TWO,
  input wire logic PROG_PIN_PAIR_THREE,
  input wire logic WDT_ENABLE,
  input wire logic WDT_WINDOWED,
  input wire logic [PRERATIO_W-1:0] WDT_PRESCALE,
  input wire logic [POSTRATIO_W-1:0] WDT_POSTSCALE
);
  // ------------------------------------------------------------
  // relations
  // ------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  wire logic [2:0] pairs = {PROG_PIN_PAIR_ONE, PROG_PIN_PAIR_TWO,
    PROG_PIN_PAIR_THREE};
  wire logic [32:0] dec = {SCAN_PORT_EN, CODE_PROTECT, PROG_MEM_WR_ALLOW,
    DEBUG_AT_RESET, pairs, WDT_ENABLE, WDT_WINDOWED, WDT_PRESCALE,
    WDT_POSTSCALE};

  zero_wait_a: assert property (PSEL && PENABLE |-> PREADY)
    else $error("apb access not answered at once");
  bad_addr_a: assert property (PSEL && PENABLE && PADDR > REG_DECODE
    |-> PSLVERR) else $error("unmapped access without error");
  load_done_a: assert property (
    FLASH_RD_REQ && FLASH_RD_ACK |=> !FLASH_RD_REQ ##1 CFG_VALID)
    else $error("fetch did not complete in two cycles");
  sys_reload_a: assert property (
    SYS_RESET && !FLASH_RD_REQ |=> FLASH_RD_REQ)
    else $error("reset source did not start a fetch");
  stable_out_a: assert property (!$past(RST) &&
    !($past(FLASH_RD_REQ, 2) && $past(FLASH_RD_ACK, 2)) |-> $stable(dec))
    else $error("decoded outputs moved outside a load");
  wr_pass_a: assert property (
    PROG_WR_VALID && PROG_MEM_WR_ALLOW |=> FLASH_WR_EN)
    else $error("permitted write not issued");
  wr_block_a: assert property (
    PROG_WR_VALID && !PROG_MEM_WR_ALLOW |=> !FLASH_WR_EN)
    else $error("protected write issued");
  wr_ones_a: assert property (FLASH_WR_EN |->
    FLASH_WR_DATA[23:16] == 8'hFF && FLASH_WR_DATA[5])
    else $error("unimplemented bits not one");
  scan_keep_a: assert property (PROG_WR_VALID &&
    PROG_VIA_SCAN && PROG_MEM_WR_ALLOW
    |=> FLASH_WR_DATA[14] == $past(SCAN_PORT_EN))
    else $error("scan enable changed over scan");
  win_en_a: assert property (WDT_WINDOWED |-> WDT_ENABLE)
    else $error("windowed without enable");
  one_pair_a: assert property ($onehot0(pairs))
    else $error("more than one pin pair");
  wdt_ratio_a: assert property ($onehot(WDT_POSTSCALE) &&
    (WDT_PRESCALE == PRESCALE_LONG || WDT_PRESCALE == PRESCALE_SHORT))
    else $error("watchdog ratio out of set");
endmodule
bind fcw_top fcw_top_props i_props (.*);
`default_nettype wire

/* bench/fcw_flash_model.sv */
// model: flash array that answers configuration word fetches
`timescale 1ns/100ps
`default_nettype none
module fcw_flash_model
  import fcw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic rd_req,
  input wire logic [1:0] lat,
  input wire logic [CW_W-1:0] mem,
  output logic rd_ack,
  output logic [CW_W-1:0] rd_data
);
  logic [1:0] cnt;
  // answers only while asked, after lat extra cycles
  always_ff @(posedge clk) begin
    if (rst || !rd_req) begin
      rd_ack <= 1'b0;
      cnt <= 2'h0;
    end else if (cnt == lat) begin
      rd_ack <= 1'b1;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
  // unread lines show the inverse so stale data cannot pass
  assign rd_data = rd_ack ? mem : ~mem;
endmodule
`default_nettype wire

/* bench/flash_config_word_one_decode_test.sv */
// testbench: loads, decode, programming and apb access of the block
`timescale 1ns/100ps
`default_nettype none
module flash_config_word_one_decode_test;
  import fcw_pkg::*;
  logic REF_CLK = 1'b0, RST = 1'b1, SYS_RESET = 1'b0;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [ADDR_W-1:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, rdat;
  logic PREADY, PSLVERR, FLASH_RD_REQ, FLASH_RD_ACK, FLASH_WR_EN, rerr;
  logic [CW_W-1:0] FLASH_RD_DATA, FLASH_WR_DATA, mem = ERASED_WORD;
  logic PROG_WR_VALID = 1'b0, PROG_VIA_SCAN = 1'b0;
  logic [CW_W-1:0] PROG_WR_DATA = 24'h0;
  logic CFG_VALID, SCAN_PORT_EN, CODE_PROTECT, PROG_MEM_WR_ALLOW;
  logic DEBUG_AT_RESET, WDT_ENABLE, WDT_WINDOWED;
  logic PROG_PIN_PAIR_ONE, PROG_PIN_PAIR_TWO, PROG_PIN_PAIR_THREE;
  logic [PRERATIO_W-1:0] WDT_PRESCALE;
  logic [POSTRATIO_W-1:0] WDT_POSTSCALE;
  logic [1:0] lat = 2'h0;
  int miscompares = 0, compares = 0, cyc = 0;
  // stored words keep bit 15 and 10 as programmers may not
  // word 0 also holds pair 00 and windowed without the enable on purpose
  logic [23:0] words [5] = '{24'h000000, 24'h00FFFF, 24'h12A2D4,
    24'h007142, 24'h00DB8F};
  wire logic [32:0] dec = {SCAN_PORT_EN, CODE_PROTECT, PROG_MEM_WR_ALLOW,
    DEBUG_AT_RESET, PROG_PIN_PAIR_ONE, PROG_PIN_PAIR_TWO,
    PROG_PIN_PAIR_THREE, WDT_ENABLE, WDT_WINDOWED, WDT_PRESCALE,
    WDT_POSTSCALE};

  fcw_top i_dut (.*);
  fcw_flash_model i_flash (.clk(REF_CLK), .rst(RST), .rd_req(FLASH_RD_REQ),
    .lat(lat), .mem(mem), .rd_ack(FLASH_RD_ACK), .rd_data(FLASH_RD_DATA));

  always #25 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      test_done();
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [32:0] expd(input logic [23:0] w);
    expd = {w[14], ~w[13], w[12], ~w[11], w[9:8] == 2'h3,
      w[9:8] == 2'h2, w[9:8] == 2'h1, w[7], ~w[6] & w[7],
      w[4] ? 8'h80 : 8'h20, 16'h0001 << w[3:0]};
  endfunction
  task automatic chk(input string n, input logic [63:0] e,
      input logic [63:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge REF_CLK);
    end while (PREADY !== 1'b1);
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wait_load();
    while (FLASH_RD_REQ !== 1'b1) begin
      @(posedge REF_CLK);
      #1;
    end
    while (FLASH_RD_REQ !== 1'b0) begin
      @(posedge REF_CLK);
      #1;
    end
    repeat (2) @(posedge REF_CLK);
    #1;
  endtask
  task automatic load(input logic [23:0] w, input logic [1:0] l);
    @(posedge REF_CLK);
    mem <= w;
    lat <= l;
    SYS_RESET <= 1'b1;
    @(posedge REF_CLK);
    SYS_RESET <= 1'b0;
    wait_load();
  endtask
  task automatic prog(input logic [23:0] d, input logic s);
    @(posedge REF_CLK);
    PROG_WR_VALID <= 1'b1;
    PROG_WR_DATA <= d;
    PROG_VIA_SCAN <= s;
    @(posedge REF_CLK);
    PROG_WR_VALID <= 1'b0;
    #1;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_boot();
    repeat (10) @(posedge REF_CLK);
    RST <= 1'b0;
    #1;
    chk("req", 1, FLASH_RD_REQ);
    chk("valid", 0, CFG_VALID);
    chk("dec", expd(ERASED_WORD), dec);
    wait_load();
    chk("valid", 1, CFG_VALID);
    chk("dec", expd(ERASED_WORD), dec);
  endtask
  task automatic t_words();
    for (int i = 0; i < 5; i++) begin
      load(words[i], i[1:0]);
      chk("dec", expd(words[i]), dec);
      apb(1'b0, REG_WORD, 32'h0);
      chk("word", {8'h00, words[i] | 24'hFF0020}, rdat);
      apb(1'b0, REG_STATUS, 32'h0);
      chk("status", {~words[i][10], ~words[i][6] & ~words[i][7],
        words[i][9:8] == 2'h0, 2'h1}, rdat & 32'h1F);
    end
  endtask
  task automatic t_prog();
    prog(24'h000400, 1'b1);
    chk("wr_en", 1, FLASH_WR_EN);
    chk("wr_data", 24'hFF4420, FLASH_WR_DATA);
    prog(24'h002400, 1'b0);
    chk("wr_data", 24'hFF2420, FLASH_WR_DATA);
    load(words[2], 2'h3);
    prog(24'h007FFF, 1'b0);
    chk("wr_en", 0, FLASH_WR_EN);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("sticky", 32'h60, rdat & 32'h60);
    apb(1'b1, REG_STATUS, 32'h60);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("cleared", 32'h0, rdat & 32'h60);
  endtask
  task automatic t_apb();
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 1, rerr);
    chk("rdata", 32'h0, rdat);
    apb(1'b1, REG_WORD, 32'h0);
    apb(1'b0, REG_WORD, 32'h0);
    chk("word", 32'h00FFA2F4, rdat);
    @(posedge REF_CLK);
    mem <= words[3];
    apb(1'b1, REG_CTRL, 32'h1);
    wait_load();
    chk("dec", expd(words[3]), dec);
  endtask
  task automatic t_rst();
    @(posedge REF_CLK);
    mem <= words[1];
    RST <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    RST <= 1'b0;
    wait_load();
    chk("dec", expd(words[1]), dec);
  endtask
  task automatic test_done();
    $display("miscompares %0d compares %0d", miscompares, compares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    t_boot();
    t_words();
    t_prog();
    t_apb();
    t_rst();
    test_done();
  end
endmodule
`default_nettype wire
